// ===== bms_scan_map.svh
`ifndef BMS_SCAN_MAP_SVH
`define BMS_SCAN_MAP_SVH

// Register indices; byte address is four times the index
`define BMS_IDX_GLOBAL_OP 8'h01
`define BMS_IDX_CELL_OP 8'h02
`define BMS_IDX_CURRENT_OP 8'h03
`define BMS_IDX_CELL_SEL_A 8'h04
`define BMS_IDX_CELL_SEL_B 8'h05
`define BMS_IDX_OTHER_UPD 8'h1b
`define BMS_IDX_POWER_CTRL 8'h24
`define BMS_IDX_SCAN_OP 8'h2e
`define BMS_IDX_FAULTS 8'h63
`define BMS_IDX_MASK_STAT 8'h65

// Global operation bits
`define BMS_GOP_SOFT_RST 7
`define BMS_GOP_RST_IDLE 6
`define BMS_GOP_BUSY 2
`define BMS_GOP_SEL 1
`define BMS_GOP_TRIG 0
// Cell and current operation bits
`define BMS_OP_TRIG 0
`define BMS_OP_CLR_FAULT 1
`define BMS_CUR_OW_RATE 6
// Scan operation fields
`define BMS_SOP_MODE_HI 7
`define BMS_SOP_MODE_LO 6
`define BMS_SOP_LPT_HI 5
`define BMS_SOP_LPT_LO 3
`define BMS_SOP_DLY_HI 2
`define BMS_SOP_DLY_LO 0
// Other update field
`define BMS_OTH_HI 5
`define BMS_OTH_LO 4
// Power control bits
`define BMS_PWR_PUMP_EN 7
`define BMS_PWR_CHG_SW 1
`define BMS_PWR_DIS_SW 0
// Mask and status bits
`define BMS_MSK_ALERT_BUSY 0
`define BMS_STA_PUMP_NRDY 5

// Reset values
`define BMS_RST_GLOBAL_OP 8'h00
`define BMS_RST_CELL_SEL 8'hff
`define BMS_RST_SCAN_OP 8'h1b
`define BMS_RST_MASK 8'h01
`define BMS_RST_PWR 8'h00

// Timing
`define BMS_CLK_HZ 20000000
`define BMS_MS_CYCLES (`BMS_CLK_HZ / 1000)
`define BMS_DLY_BASE_MS 64
`define BMS_LPT_BASE_SCANS 512
`define BMS_OW_SLOW_PERIOD 8

`endif

// ===== bms_scan_pkg.sv
package bms_scan_pkg;
   typedef enum logic [1:0] {
      MODE_IDLE = 2'b00,
      MODE_SCAN = 2'b01,
      MODE_LOWPWR = 2'b10,
      MODE_SHIP = 2'b11
   } bms_mode_t;
   typedef enum logic [1:0] {
      SEQ_WAIT = 2'b00,
      SEQ_MEAS = 2'b01,
      SEQ_DELAY = 2'b10
   } bms_seq_t;
endpackage

// ===== bms_scan_sequencer.sv
// Added by the designer: register access over APB.
`timescale 1ns/100ps
`include "bms_scan_map.svh"

module bms_scan_sequencer #(
   parameter int MS_CYCLES = `BMS_MS_CYCLES,
   parameter int ADDR_W = 10
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic chargeAboveIn,
   input wire logic dischargeAboveIn,
   input wire logic pumpReadyIn,
   input wire logic overvoltageFault,
   input wire logic undervoltageFault,
   input wire logic measDone,
   output logic measStart,
   output logic [3:0] measKind,
   output logic [15:0] measCells,
   output logic busy,
   output logic alert_out_n,
   output logic [1:0] mode,
   output logic charge_current_flag,
   output logic discharge_current_flag,
   output logic pump_enable,
   output logic charge_switch,
   output logic discharge_switch
);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [1:0] chgSync_reg, disSync_reg, pumpSync_reg;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         chgSync_reg <= 2'h0;
         disSync_reg <= 2'h0;
         pumpSync_reg <= 2'h0;
      end else begin
         chgSync_reg <= {chgSync_reg[0], chargeAboveIn};
         disSync_reg <= {disSync_reg[0], dischargeAboveIn};
         pumpSync_reg <= {pumpSync_reg[0], pumpReadyIn};
      end
   end
   wire chgAbove = chgSync_reg[1];
   wire disAbove = disSync_reg[1];
   wire pumpReady = pumpSync_reg[1];

   ////////////////////////////////////////////////////////////////////////
   // APB slave: one wait state so read data comes from a flop
   logic pready_reg, pslverr_reg;
   logic [31:0] prdata_reg;
   wire [7:0] regIdx = 8'(paddr[ADDR_W-1:2]);
   wire alignedAddr = (paddr[1:0] == 2'h0);
   wire hitGop = alignedAddr && regIdx == `BMS_IDX_GLOBAL_OP;
   wire hitCell = alignedAddr && regIdx == `BMS_IDX_CELL_OP;
   wire hitCur = alignedAddr && regIdx == `BMS_IDX_CURRENT_OP;
   wire hitSelA = alignedAddr && regIdx == `BMS_IDX_CELL_SEL_A;
   wire hitSelB = alignedAddr && regIdx == `BMS_IDX_CELL_SEL_B;
   wire hitOth = alignedAddr && regIdx == `BMS_IDX_OTHER_UPD;
   wire hitPwr = alignedAddr && regIdx == `BMS_IDX_POWER_CTRL;
   wire hitSop = alignedAddr && regIdx == `BMS_IDX_SCAN_OP;
   wire hitFlt = alignedAddr && regIdx == `BMS_IDX_FAULTS;
   wire hitMsk = alignedAddr && regIdx == `BMS_IDX_MASK_STAT;
   wire hitAny = hitGop | hitCell | hitCur | hitSelA | hitSelB | hitOth |
      hitPwr | hitSop | hitFlt | hitMsk;
   wire accessEnd = psel && penable && pready_reg;
   wire wrEn = accessEnd && pwrite;
   wire [7:0] wd = pwdata[7:0];
   wire gopWr = wrEn && hitGop;
   wire softRst = gopWr && wd[`BMS_GOP_SOFT_RST];

   ////////////////////////////////////////////////////////////////////////
   // Register file
   logic scanSel_reg, owSlow_reg, alertMask_reg;
   logic [7:0] cellSelA_reg, cellSelB_reg;
   logic [1:0] othRate_reg, faults_reg;
   logic [2:0] lpCode_reg, dlyCode_reg;
   logic pumpEn_reg, chgSw_reg, disSw_reg, pumpNrdy_reg;
   logic [1:0] mode_reg, mode_next;
   logic chgSw_next, disSw_next, lpEnter;

   wire isIdle = (mode_reg == bms_scan_pkg::MODE_IDLE);
   wire canScan = (mode_reg == bms_scan_pkg::MODE_SCAN) ||
      (mode_reg == bms_scan_pkg::MODE_LOWPWR);
   wire rstIdle = gopWr && wd[`BMS_GOP_RST_IDLE];

   // Low-power entry wins over a scan-operation write in the same cycle; reset-to-idle wins over both
   assign mode_next = rstIdle ? bms_scan_pkg::MODE_IDLE :
      lpEnter ? bms_scan_pkg::MODE_LOWPWR :
      (wrEn && hitSop) ? wd[`BMS_SOP_MODE_HI:`BMS_SOP_MODE_LO] :
      mode_reg;

   // Direction qualifiers are forced true in IDLE
   wire qualChg = isIdle || charge_current_flag;
   wire qualDis = isIdle || discharge_current_flag;
   wire [1:0] faultSet = {undervoltageFault && qualDis,
      overvoltageFault && qualChg};
   wire faultClr = wrEn && hitCell && wd[`BMS_OP_CLR_FAULT];

   // Automatic switch-off only outside IDLE
   assign chgSw_next = (wrEn && hitPwr) ? wd[`BMS_PWR_CHG_SW] :
      (!isIdle && faultSet[0]) ? 1'b0 : chgSw_reg;
   assign disSw_next = (wrEn && hitPwr) ? wd[`BMS_PWR_DIS_SW] :
      (!isIdle && faultSet[1]) ? 1'b0 : disSw_reg;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         scanSel_reg <= 1'(`BMS_RST_GLOBAL_OP >> `BMS_GOP_SEL);
         cellSelA_reg <= `BMS_RST_CELL_SEL;
         cellSelB_reg <= `BMS_RST_CELL_SEL;
         {mode_reg, lpCode_reg, dlyCode_reg} <= `BMS_RST_SCAN_OP;
         alertMask_reg <= 1'(`BMS_RST_MASK);
         {pumpEn_reg, chgSw_reg, disSw_reg} <= 3'h0;
         {owSlow_reg, othRate_reg, faults_reg} <= 5'h00;
      end else if (softRst) begin
         scanSel_reg <= 1'(`BMS_RST_GLOBAL_OP >> `BMS_GOP_SEL);
         cellSelA_reg <= `BMS_RST_CELL_SEL;
         cellSelB_reg <= `BMS_RST_CELL_SEL;
         {mode_reg, lpCode_reg, dlyCode_reg} <= `BMS_RST_SCAN_OP;
         alertMask_reg <= 1'(`BMS_RST_MASK);
         {pumpEn_reg, chgSw_reg, disSw_reg} <= 3'h0;
         {owSlow_reg, othRate_reg, faults_reg} <= 5'h00;
      end else begin
         if (gopWr) scanSel_reg <= wd[`BMS_GOP_SEL];
         if (wrEn && hitSelA) cellSelA_reg <= wd;
         if (wrEn && hitSelB) cellSelB_reg <= wd;
         if (wrEn && hitSop) begin
            lpCode_reg <= wd[`BMS_SOP_LPT_HI:`BMS_SOP_LPT_LO];
            dlyCode_reg <= wd[`BMS_SOP_DLY_HI:`BMS_SOP_DLY_LO];
         end
         mode_reg <= mode_next;
         if (wrEn && hitMsk) alertMask_reg <= wd[`BMS_MSK_ALERT_BUSY];
         if (wrEn && hitCur) owSlow_reg <= wd[`BMS_CUR_OW_RATE];
         if (wrEn && hitOth) othRate_reg <= wd[`BMS_OTH_HI:`BMS_OTH_LO];
         if (wrEn && hitPwr) pumpEn_reg <= wd[`BMS_PWR_PUMP_EN];
         chgSw_reg <= chgSw_next;
         disSw_reg <= disSw_next;
         // Set wins over clear
         faults_reg <= (faults_reg & ~{2{faultClr}}) | faultSet;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) pumpNrdy_reg <= 1'b1;
      else pumpNrdy_reg <= !(pumpEn_reg && pumpReady);
   end

   ////////////////////////////////////////////////////////////////////////
   // Scan sequencer
   bms_scan_pkg::bms_seq_t seq_reg, seq_next;
   logic runCont_reg, runCont_next, scanActive_reg, scanActive_next;
   logic launch, busy_reg, alert_reg;
   logic [3:0] kind_next, measKind_reg;
   logic [15:0] measCells_reg;
   logic [2:0] scanNum_reg;
   logic [31:0] msCnt_reg;
   logic [12:0] dlyCnt_reg;
   logic [15:0] quietCnt_reg;
   logic measStart_reg, chgFlag_reg, disFlag_reg;

   wire trigWr = gopWr && wd[`BMS_GOP_TRIG];
   wire stopReq = gopWr && wd[`BMS_GOP_SEL] && !wd[`BMS_GOP_TRIG];
   // Trigger is dropped outside SCAN and LOW POWER
   wire scanStart = trigWr && canScan &&
      seq_reg == bms_scan_pkg::SEQ_WAIT;
   wire cellTrig = wrEn && hitCell && wd[`BMS_OP_TRIG];
   wire curTrig = wrEn && hitCur && wd[`BMS_OP_TRIG];
   // Individual triggers ignore the mode
   wire indivStart = (cellTrig || curTrig) && !trigWr &&
      seq_reg == bms_scan_pkg::SEQ_WAIT;
   wire [12:0] dlyMs = (dlyCode_reg == 3'h0) ? 13'h0000 :
      13'(`BMS_DLY_BASE_MS << (dlyCode_reg - 3'h1));
   wire msTick = (msCnt_reg == 32'(MS_CYCLES - 1));
   wire dlyDone = (dlyCnt_reg >= dlyMs);
   wire scanDone = seq_reg == bms_scan_pkg::SEQ_MEAS && measDone &&
      scanActive_reg;
   // Other and open-wire repeat on every scan unless their rate settings are non-zero
   wire [2:0] othMask = 3'((4'h1 << othRate_reg) - 4'h1);
   wire owDue = !owSlow_reg ||
      scanNum_reg == 3'(`BMS_OW_SLOW_PERIOD % 8);
   wire othDue = (scanNum_reg & othMask) == 3'h0;
   wire firstScan = (seq_reg == bms_scan_pkg::SEQ_WAIT);

   always_comb begin
      seq_next = seq_reg;
      runCont_next = runCont_reg && !stopReq && canScan;
      scanActive_next = scanActive_reg;
      launch = 1'b0;
      kind_next = measKind_reg;
      case (seq_reg)
         bms_scan_pkg::SEQ_WAIT: begin
            if (scanStart) begin
               seq_next = bms_scan_pkg::SEQ_MEAS;
               runCont_next = !wd[`BMS_GOP_SEL];
               scanActive_next = 1'b1;
               launch = 1'b1;
               kind_next = 4'hf;
            end else if (indivStart) begin
               seq_next = bms_scan_pkg::SEQ_MEAS;
               scanActive_next = 1'b0;
               launch = 1'b1;
               kind_next = cellTrig ? 4'h1 : 4'h2;
            end
         end
         bms_scan_pkg::SEQ_MEAS: begin
            if (measDone) begin
               // Only soft reset cuts a scan short; stop acts at its end
               if (scanActive_reg && runCont_next) begin
                  seq_next = bms_scan_pkg::SEQ_DELAY;
               end else begin
                  seq_next = bms_scan_pkg::SEQ_WAIT;
               end
            end
         end
         bms_scan_pkg::SEQ_DELAY: begin
            if (!runCont_next) begin
               seq_next = bms_scan_pkg::SEQ_WAIT;
            end else if (dlyDone) begin
               seq_next = bms_scan_pkg::SEQ_MEAS;
               launch = 1'b1;
               kind_next = {owDue, othDue, 2'h3};
            end
         end
         default: seq_next = bms_scan_pkg::SEQ_WAIT;
      endcase
      if (firstScan && !launch) kind_next = measKind_reg;
   end

   wire [2:0] lpShift = lpCode_reg - 3'h1;
   wire [15:0] lpTarget = 16'((17'(`BMS_LPT_BASE_SCANS) << lpShift) - 17'h1);
   wire quiet = !chgAbove && !disAbove;
   assign lpEnter = scanDone && quiet && lpCode_reg != 3'h0 &&
      mode_reg == bms_scan_pkg::MODE_SCAN &&
      quietCnt_reg == lpTarget;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         seq_reg <= bms_scan_pkg::SEQ_WAIT;
         runCont_reg <= 1'b0;
         scanActive_reg <= 1'b0;
         measKind_reg <= 4'h0;
         measStart_reg <= 1'b0;
         measCells_reg <= 16'h0000;
      end else begin
         seq_reg <= softRst ? bms_scan_pkg::SEQ_WAIT : seq_next;
         runCont_reg <= !softRst && runCont_next;
         scanActive_reg <= scanActive_next;
         measKind_reg <= kind_next;
         measStart_reg <= launch && !softRst;
         if (launch) measCells_reg <= {cellSelB_reg, cellSelA_reg};
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         msCnt_reg <= 32'h0;
         dlyCnt_reg <= 13'h0000;
         scanNum_reg <= 3'h0;
         quietCnt_reg <= 16'h0000;
      end else begin
         if (seq_reg != bms_scan_pkg::SEQ_DELAY || msTick) msCnt_reg <= 32'h0;
         else msCnt_reg <= msCnt_reg + 32'h1;
         if (seq_reg != bms_scan_pkg::SEQ_DELAY) dlyCnt_reg <= 13'h0000;
         else if (msTick && !dlyDone) dlyCnt_reg <= dlyCnt_reg + 13'h0001;
         if (scanStart) scanNum_reg <= 3'h0;
         else if (scanDone) scanNum_reg <= scanNum_reg + 3'h1;
         if (softRst || lpEnter || (scanDone && !quiet)) begin
            quietCnt_reg <= 16'h0000;
         end else if (scanDone && quiet && lpCode_reg != 3'h0) begin
            quietCnt_reg <= quietCnt_reg + 16'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status outputs
   wire busyNext = (seq_next == bms_scan_pkg::SEQ_MEAS) && !softRst;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         busy_reg <= 1'b0;
         alert_reg <= 1'b1;
         chgFlag_reg <= 1'b0;
         disFlag_reg <= 1'b0;
      end else begin
         busy_reg <= busyNext;
         alert_reg <= alertMask_reg || !busyNext;
         if (scanDone && !isIdle) begin
            chgFlag_reg <= chgAbove;
            disFlag_reg <= disAbove;
         end
      end
   end

   wire [7:0] rdMux =
      hitGop ? {5'h00, busy_reg, scanSel_reg, 1'b0} :
      hitSelA ? cellSelA_reg :
      hitSelB ? cellSelB_reg :
      hitCur ? {1'b0, owSlow_reg, 6'h00} :
      hitOth ? {2'h0, othRate_reg, 4'h0} :
      hitPwr ? {pumpEn_reg, 5'h00, chgSw_reg, disSw_reg} :
      hitSop ? {mode_reg, lpCode_reg, dlyCode_reg} :
      hitFlt ? {6'h00, faults_reg} :
      hitMsk ? {2'h0, pumpNrdy_reg, 4'h0, alertMask_reg} : 8'h00;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0;
      end else begin
         pready_reg <= psel && penable && !pready_reg;
         pslverr_reg <= psel && penable && !pready_reg && !hitAny;
         if (psel && penable && !pready_reg) prdata_reg <= {24'h0, rdMux};
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign measStart = measStart_reg;
   assign measKind = measKind_reg;
   assign measCells = measCells_reg;
   assign busy = busy_reg;
   assign alert_out_n = alert_reg;
   assign mode = mode_reg;
   assign charge_current_flag = chgFlag_reg;
   assign discharge_current_flag = disFlag_reg;
   assign pump_enable = pumpEn_reg;
   assign charge_switch = chgSw_reg;
   assign discharge_switch = disSw_reg;

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   property p_arm_no_start;
      gopWr && wd[1:0] == 2'h0 && seq_reg == bms_scan_pkg::SEQ_WAIT
         |=> !measStart_reg && seq_reg == bms_scan_pkg::SEQ_WAIT;
   endproperty
   a_arm_no_start: assert property (p_arm_no_start)
      else $error("armed write started a scan");
   property p_cont_start;
      scanStart && !wd[`BMS_GOP_SEL] && !softRst
         |=> measStart_reg && runCont_reg && measKind_reg == 4'hf;
   endproperty
   a_cont_start: assert property (p_cont_start)
      else $error("continuous scan did not start");
   property p_stop;
      stopReq |=> !runCont_reg;
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop write left scanning running");
   property p_delay_hold;
      seq_reg == bms_scan_pkg::SEQ_DELAY && !dlyDone |=> !measStart_reg;
   endproperty
   a_delay_hold: assert property (p_delay_hold)
      else $error("scan started before delay expired");
   property p_lp_enter;
      lpEnter && !rstIdle && !softRst
         |=> mode_reg == bms_scan_pkg::MODE_LOWPWR;
   endproperty
   a_lp_enter: assert property (p_lp_enter)
      else $error("low power not entered");
   property p_quiet_clear;
      scanDone && !quiet |=> quietCnt_reg == 16'h0000;
   endproperty
   a_quiet_clear: assert property (p_quiet_clear)
      else $error("quiet count not restarted");
   property p_reset_idle;
      rstIdle |=> mode_reg == bms_scan_pkg::MODE_IDLE;
   endproperty
   a_reset_idle: assert property (p_reset_idle)
      else $error("reset to idle ignored");
   property p_idle_trig;
      trigWr && isIdle && seq_reg == bms_scan_pkg::SEQ_WAIT
         |=> !measStart_reg ##1 !measStart_reg;
   endproperty
   a_idle_trig: assert property (p_idle_trig)
      else $error("trigger acted in idle");
   property p_idle_flags;
      isIdle |=> charge_current_flag == $past(charge_current_flag) &&
         discharge_current_flag == $past(discharge_current_flag);
   endproperty
   a_idle_flags: assert property (p_idle_flags)
      else $error("direction flag changed in idle");
   property p_cell_trig;
      cellTrig && !trigWr && !softRst && seq_reg == bms_scan_pkg::SEQ_WAIT
         |=> measStart_reg && measKind_reg == 4'h1 && busy_reg;
   endproperty
   a_cell_trig: assert property (p_cell_trig)
      else $error("cell trigger failed");
   property p_cells;
      measStart_reg |-> measCells_reg ==
         {$past(cellSelB_reg), $past(cellSelA_reg)};
   endproperty
   a_cells: assert property (p_cells)
      else $error("cell mask not passed on");
   property p_pump;
      pumpEn_reg && pumpReady |=> !pumpNrdy_reg;
   endproperty
   a_pump: assert property (p_pump)
      else $error("pump not ready still set");
   property p_alert;
      busy_reg && !$past(alertMask_reg) |-> !alert_reg;
   endproperty
   a_alert: assert property (p_alert)
      else $error("alert high while busy");

   c_single: cover property (scanStart && wd[`BMS_GOP_SEL]);
   c_cont_delay: cover property (seq_reg == bms_scan_pkg::SEQ_DELAY
      ##1 measStart_reg);
   c_lp: cover property (lpEnter);
   c_idle_indiv: cover property (indivStart && isIdle);

endmodule // bms_scan_sequencer

// ===== bms_meas_engine_model.sv
`timescale 1ns/100ps
// Stands in for the measurement engine; a fixed latency keeps gaps exact
module bms_meas_engine_model #(
   parameter int LAT = 5
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic measStart,
   output logic measDone
);
   int cnt;
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 0;
         measDone <= 1'b0;
      end else begin
         measDone <= (cnt == 1);
         if (measStart)
            cnt <= LAT;
         else if (cnt > 0)
            cnt <= cnt - 1;
      end
   end
endmodule // bms_meas_engine_model

// ===== battery_monitor_scan_sequencer_bench.sv
`timescale 1ns/100ps
module battery_monitor_scan_sequencer_bench;
   logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [9:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic pready, pslverr, chgIn = 0, measStart, measDone, busy;
   logic alert_out_n, pumpEn, chgFlag, maskOff = 0, err;
   logic disIn = 0, pumpRdyIn = 0, ovIn = 0, uvIn = 0, disFlag, chgSw, disSw;
   logic [3:0] measKind;
   logic [15:0] measCells;
   logic [1:0] mode;
   logic [7:0] rd;
   int err_count = 0, n_compared = 0, starts = 0, cyc = 0, lastStart = 0;
   int gap = 0, base;
   always #25 clock = ~clock;
   bms_scan_sequencer #(.MS_CYCLES(4)) dut (.clock(clock), .rst_n(rst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .chargeAboveIn(chgIn), .dischargeAboveIn(disIn),
      .pumpReadyIn(pumpRdyIn), .overvoltageFault(ovIn),
      .undervoltageFault(uvIn),
      .measDone(measDone), .measStart(measStart), .measKind(measKind),
      .measCells(measCells), .busy(busy), .alert_out_n(alert_out_n),
      .mode(mode), .charge_current_flag(chgFlag),
      .discharge_current_flag(disFlag), .pump_enable(pumpEn),
      .charge_switch(chgSw), .discharge_switch(disSw));
   bms_meas_engine_model #(.LAT(5)) eng (.clock(clock), .rst_n(rst_n),
      .measStart(measStart), .measDone(measDone));
   ////////////////////////////////////////////////////////////////////////
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask
   task stop_test;
      $display("Counts: %0d compared, %0d mismatched", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Mid-cycle sampling keeps the start count clear of edge races
   always @(negedge clock) begin
      cyc++;
      if (measStart === 1'b1) begin
         gap = cyc - lastStart;
         lastStart = cyc;
         starts++;
      end
      if (maskOff && busy === 1'b1)
         chk("alert", 0, alert_out_n);
   end
   task apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         chk("pready", 1, 0);
         stop_test;
      end
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask
   task waitStarts(input int k, input int lim);
      for (int n = 0; n < lim && starts < k; n++)
         @(posedge clock);
      if (starts < k) begin
         chk("starts", k, starts);
         stop_test;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      apb(0, 8'h2e, 8'h00);
      chk("scan_operation", 8'h1b, rd);
      apb(0, 8'h04, 8'h00);
      chk("cell_select_a", 8'hff, rd);
      chk("mode", 2'b00, mode);
      apb(0, 8'h10, 8'h00);
      chk("unmapped", 1, err);
      $display("test reset done");
      apb(1, 8'h65, 8'h00);
      maskOff = 1;
      apb(1, 8'h01, 8'h03);
      apb(1, 8'h01, 8'h01);
      repeat (20) @(posedge clock);
      chk("idle starts", 0, starts);
      apb(1, 8'h04, 8'h7f);
      chgIn <= 1'b1;
      disIn <= 1'b1;
      apb(1, 8'h02, 8'h01);
      waitStarts(1, 50);
      chk("kind", 4'h1, measKind);
      chk("cells", 16'hff7f, measCells);
      repeat (10) @(posedge clock);
      apb(1, 8'h03, 8'h01);
      waitStarts(2, 50);
      repeat (10) @(posedge clock);
      chk("idle flag", 0, chgFlag);
      apb(1, 8'h24, 8'h83);
      chk("charge_switch", 1, chgSw);
      chk("discharge_switch", 1, disSw);
      repeat (5) @(posedge clock);
      apb(0, 8'h65, 8'h00);
      chk("pump not ready", 1, rd[5]);
      pumpRdyIn <= 1'b1;
      ovIn <= 1'b1;
      uvIn <= 1'b1;
      repeat (5) @(posedge clock);
      ovIn <= 1'b0;
      uvIn <= 1'b0;
      apb(0, 8'h65, 8'h00);
      chk("pump_not_ready", 0, rd[5]);
      chk("pump_enable", 1, pumpEn);
      apb(0, 8'h63, 8'h00);
      chk("idle faults", 8'h03, rd);
      chk("idle switches", 2'b11, {chgSw, disSw});
      apb(1, 8'h02, 8'h02);
      apb(0, 8'h63, 8'h00);
      chk("fault clear", 8'h00, rd);
      $display("test idle done");
      apb(1, 8'h2e, 8'h40);
      chk("scan mode", 2'b01, mode);
      base = starts;
      apb(1, 8'h01, 8'h03);
      repeat (40) @(posedge clock);
      chk("single", base + 1, starts);
      chk("scan flag", 1, chgFlag);
      chk("discharge flag", 1, disFlag);
      // Charge flag is set, so an overvoltage now must open the charge switch
      ovIn <= 1'b1;
      repeat (2) @(posedge clock);
      ovIn <= 1'b0;
      chk("scan switches", 2'b01, {chgSw, disSw});
      chgIn <= 1'b0;
      disIn <= 1'b0;
      apb(1, 8'h01, 8'h00);
      repeat (40) @(posedge clock);
      chk("armed", base + 1, starts);
      $display("test single done");
      // Settings change only while stopped, as the host must
      apb(1, 8'h2e, 8'h41);
      apb(1, 8'h01, 8'h01);
      waitStarts(base + 4, 2000);
      chk("gap", 1, gap >= 260 && gap <= 272);
      apb(1, 8'h01, 8'h02);
      repeat (20) @(posedge clock);
      base = starts;
      repeat (600) @(posedge clock);
      chk("stopped", base, starts);
      $display("test continuous done");
      apb(1, 8'h2e, 8'h48);
      base = starts;
      apb(1, 8'h01, 8'h01);
      for (int n = 0; n < 20000 && mode !== 2'b10; n++)
         @(posedge clock);
      chk("low power", 2'b10, mode);
      chk("quiet", 1, starts - base >= 512 && starts - base <= 514);
      apb(1, 8'h01, 8'h02);
      repeat (20) @(posedge clock);
      chgIn <= 1'b1;
      repeat (5) @(posedge clock);
      base = starts;
      apb(1, 8'h01, 8'h01);
      waitStarts(base + 1, 50);
      // Reset-to-idle lands before this scan ends, so its flags must freeze
      apb(1, 8'h01, 8'h40);
      repeat (20) @(posedge clock);
      chk("idle mode", 2'b00, mode);
      chk("idle freeze", 0, chgFlag);
      chk("idle stop", base + 1, starts);
      $display("test low power done");
      maskOff = 0;
      apb(1, 8'h01, 8'h80);
      repeat (3) @(posedge clock);
      chk("soft mode", 2'b00, mode);
      apb(0, 8'h2e, 8'h00);
      chk("soft scan_op", 8'h1b, rd);
      $display("test soft reset done");
      stop_test;
   end
endmodule // battery_monitor_scan_sequencer_bench
